// ---- inc/sms_pkg.sv ----
// Shared constants and types for the mode/supply control register bank.
// Assumes a single 20 MHz system clock; SPI pins arrive asynchronously.
package sms_pkg;

    // Register addresses as carried in the SPI header byte
    localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] ADDR_HW_CTRL0 = 7'h02;
    localparam logic [6:0] ADDR_WATCHDOG_CONTROL = 7'h03;

    // Power-on / soft reset values
    localparam logic [7:0] MODE_SUPPLY_RESET = 8'h00;
    localparam logic [7:0] HW_CTRL0_RESET = 8'h00;
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h14;

    // Writable bits; reserved bits are forced to zero
    localparam logic [7:0] MODE_SUPPLY_RW_MASK = 8'hdf;
    localparam logic [7:0] HW_CTRL0_RW_MASK = 8'h65;
    localparam logic [7:0] WATCHDOG_CONTROL_RW_MASK = 8'hf7;

    // Restart behaviour: kept bits, then forced-one bits
    localparam logic [7:0] MODE_SUPPLY_RESTART_KEEP = 8'h03;
    localparam logic [7:0] HW_CTRL0_RESTART_KEEP = 8'h45;
    localparam logic [7:0] WATCHDOG_CONTROL_RESTART_KEEP = 8'hb0;
    localparam logic [7:0] WATCHDOG_CONTROL_RESTART_SET = 8'h04;

    // Field positions
    localparam int unsigned MS_MODE_LSB = 6;
    localparam int unsigned MS_POLICY_LSB = 3;
    localparam int unsigned MS_OV_EN_BIT = 2;
    localparam int unsigned MS_LOW_FIELDS_MSB = 4;
    localparam int unsigned HW_SRST_BIT = 6;
    localparam int unsigned HW_FO_BIT = 5;
    localparam int unsigned HW_CP_BIT = 2;
    localparam int unsigned HW_WDCNT_BIT = 0;
    localparam int unsigned SPI_WRITE_BIT = 7;

    // Mode field codes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    localparam logic [1:0] MODE_SOFT_RESET = 2'h3;

    // Secondary regulator policy codes
    localparam logic [1:0] POL_OFF = 2'h0;
    localparam logic [1:0] POL_NORMAL = 2'h1;
    localparam logic [1:0] POL_NORMAL_STOP = 2'h2;
    localparam logic [1:0] POL_ALWAYS = 2'h3;

    // SPI frame geometry
    localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
    localparam logic [4:0] SPI_HEADER_BITS = 5'h08;
    localparam logic [4:0] SPI_COUNT_MAX = 5'h1f;

    // Present device state, driven by the mode state machine
    typedef enum logic [5:0] {
        SMS_ST_INIT = 6'b000001,
        SMS_ST_NORMAL = 6'b000010,
        SMS_ST_SLEEP = 6'b000100,
        SMS_ST_STOP = 6'b001000,
        SMS_ST_RESTART = 6'b010000,
        SMS_ST_FAILSAFE = 6'b100000
    } sms_sbc_state_t;

    typedef struct packed {
        logic csN;
        logic sclk;
        logic sdi;
    } sms_spi_pins_t;

    typedef struct packed {
        logic write;
        logic [6:0] addr;
        logic [7:0] data;
    } sms_frame_t;

endpackage

// ---- hw/sms_pin_sync.sv ----
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the inputs are quasi-static relative to several mclk periods.
`timescale 1ns/1ps
module sms_pin_sync #(
    parameter int unsigned W = 3,
    parameter logic [W-1:0] IDLE = '0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sms_sync_state_t;

    sms_sync_state_t st_reg;
    sms_sync_state_t st_next;

    // Only the second stage is visible to logic
    always_comb begin
        st_next = st_reg;
        st_next.stage1 = pinIn;
        st_next.stage2 = st_reg.stage1;
    end

    // Reset to the pins' idle levels so no false edge follows reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '{stage1: IDLE, stage2: IDLE};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign pinOut = st_reg.stage2;
endmodule

// ---- hw/sms_spi_frame.sv ----
// SPI slave framer: 16-bit frames, MSB first, header byte then data byte.
// Assumes synchronised pins; samples on rising SCLK, shifts SDO on falling.
`timescale 1ns/1ps
module sms_spi_frame (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire sms_pkg::sms_spi_pins_t pins,
    input wire logic [7:0] firstByte,
    input wire logic [7:0] readByte,
    output logic [6:0] hdrAddr,
    output logic sdo,
    output logic sdoOe,
    output sms_pkg::sms_frame_t frame,
    output logic frameValid,
    output logic frameError
);
    typedef enum logic [1:0] {
        SPI_IDLE = 2'b01,
        SPI_SHIFT = 2'b10
    } sms_spi_fsm_t;

    typedef struct packed {
        sms_spi_fsm_t fsm;
        logic sclkPrev;
        logic [4:0] bitCnt;
        logic [15:0] rx;
        logic [7:0] tx;
        logic oe;
        sms_pkg::sms_frame_t frame;
        logic valid;
        logic error;
    } sms_spi_state_t;

    sms_spi_state_t st_reg;
    sms_spi_state_t st_next;
    logic sclkRise;
    logic sclkFall;

    // Edges seen on the synchronised clock
    assign sclkRise = pins.sclk && !st_reg.sclkPrev;
    assign sclkFall = !pins.sclk && st_reg.sclkPrev;

    // Frame sequencing
    always_comb begin
        st_next = st_reg;
        st_next.sclkPrev = pins.sclk;
        st_next.valid = 1'b0;
        st_next.error = 1'b0;
        unique case (st_reg.fsm)
            SPI_IDLE: begin
                if (!pins.csN) begin
                    st_next.fsm = SPI_SHIFT;
                    st_next.bitCnt = '0;
                    st_next.tx = firstByte;
                    st_next.oe = 1'b1;
                end
            end
            SPI_SHIFT: begin
                if (pins.csN) begin
                    // Wrong length frames are dropped whole
                    st_next.fsm = SPI_IDLE;
                    st_next.oe = 1'b0;
                    if (st_reg.bitCnt == sms_pkg::SPI_FRAME_BITS) begin
                        st_next.valid = 1'b1;
                        st_next.frame.write = st_reg.rx[8 + sms_pkg::SPI_WRITE_BIT];
                        st_next.frame.addr = st_reg.rx[14:8];
                        st_next.frame.data = st_reg.rx[7:0];
                    end else begin
                        st_next.error = 1'b1;
                    end
                end else if (sclkRise) begin
                    st_next.rx = {st_reg.rx[14:0], pins.sdi};
                    if (st_reg.bitCnt != sms_pkg::SPI_COUNT_MAX) begin
                        st_next.bitCnt = st_reg.bitCnt + 5'h01;
                    end
                end else if (sclkFall) begin
                    // Old contents go out before any write lands
                    if (st_reg.bitCnt == sms_pkg::SPI_HEADER_BITS) begin
                        st_next.tx = readByte;
                    end else begin
                        st_next.tx = {st_reg.tx[6:0], 1'b0};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '{fsm: SPI_IDLE, default: '0};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign hdrAddr = st_reg.rx[6:0];
    assign sdo = st_reg.tx[7];
    assign sdoOe = st_reg.oe;
    assign frame = st_reg.frame;
    assign frameValid = st_reg.valid;
    assign frameError = st_reg.error;
endmodule

// ---- hw/sms_mode_supply_regs.sv ----
// Mode/supply control, hardware control 0 and watchdog control registers.
// Assumes the mode state machine, lock bits and failure status live
// outside and arrive on mclk; SPI pins arrive asynchronously.
`timescale 1ns/1ps

module sms_mode_supply_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic spiCsN,
    input wire logic spiSclk,
    input wire logic spiSdi,
    output logic spiSdo,
    output logic spiSdoOe,
    input wire sms_pkg::sms_sbc_state_t sbcState,
    input wire logic devMode,
    input wire logic enterRestart,
    input wire logic overTemp,
    input wire logic primaryOvEvent,
    input wire logic cfgLock0,
    input wire logic cfgLock1,
    input wire logic failureActive,
    input wire logic pinIsFailOutput,
    output logic [1:0] modeRequest,
    output logic modeRequestValid,
    output logic softResetRequest,
    output logic resetPinLowRequest,
    output logic spiFailSet,
    output logic primaryOvFlagSet,
    output logic primaryOvRestartReq,
    output logic secRegOn,
    output logic [1:0] resetThresholdSel,
    output logic chargePumpOn,
    output logic failOutputActive,
    output logic wdFailCountSel,
    output logic [7:0] watchdogControl
);
    typedef struct packed {
        logic [7:0] modeSupply;
        logic [7:0] hwCtrl0;
        logic [7:0] wdCtrl;
        logic [1:0] modeReq;
        logic modeReqValid;
        logic softReset;
        logic resetLow;
        logic spiFail;
        logic ovFlag;
        logic ovRestart;
        logic secOn;
        logic failOut;
    } sms_regs_state_t;

    sms_regs_state_t st_reg;
    sms_regs_state_t st_next;

    sms_pkg::sms_spi_pins_t pinsRaw;
    sms_pkg::sms_spi_pins_t pinsSync;
    sms_pkg::sms_frame_t frame;
    logic frameValid;
    logic [6:0] hdrAddr;
    logic [7:0] readByte;

    // Pins cross into mclk before the framer sees them
    assign pinsRaw = '{csN: spiCsN, sclk: spiSclk, sdi: spiSdi};

    sms_pin_sync #(
        .W(3),
        .IDLE(3'h4) // Chip select idles high, clock and data low
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .pinIn(pinsRaw),
        .pinOut(pinsSync)
    );

    sms_spi_frame u_frame (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .pins(pinsSync),
        .firstByte(st_reg.modeSupply),
        .readByte(readByte),
        .hdrAddr(hdrAddr),
        .sdo(spiSdo),
        .sdoOe(spiSdoOe),
        .frame(frame),
        .frameValid(frameValid),
        .frameError()
    );

    // Read mux; stored values already hold zeros in reserved bits
    always_comb begin
        unique case (hdrAddr)
            sms_pkg::ADDR_MODE_SUPPLY: readByte = st_reg.modeSupply;
            sms_pkg::ADDR_HW_CTRL0: readByte = st_reg.hwCtrl0;
            sms_pkg::ADDR_WATCHDOG_CONTROL: readByte = st_reg.wdCtrl;
            default: readByte = 8'h00;
        endcase
    end

    // Register updates: SPI write first, then hardware events override
    always_comb begin
        logic wrMs;
        logic wrHw;
        logic wrWd;
        logic inStop;
        logic [1:0] reqMode;
        logic [1:0] policy;
        logic [7:0] hwKeep;
        wrMs = frameValid && frame.write && (frame.addr == sms_pkg::ADDR_MODE_SUPPLY);
        wrHw = frameValid && frame.write && (frame.addr == sms_pkg::ADDR_HW_CTRL0);
        wrWd = frameValid && frame.write && (frame.addr == sms_pkg::ADDR_WATCHDOG_CONTROL);
        inStop = (sbcState == sms_pkg::SMS_ST_STOP);
        reqMode = frame.data[sms_pkg::MS_MODE_LSB +: 2];
        policy = st_reg.modeSupply[sms_pkg::MS_POLICY_LSB +: 2];
        hwKeep = 8'h00;

        st_next = st_reg;
        st_next.modeReqValid = 1'b0;
        st_next.softReset = 1'b0;
        st_next.resetLow = 1'b0;
        st_next.spiFail = 1'b0;
        st_next.ovFlag = 1'b0;
        st_next.ovRestart = 1'b0;

        // Mode and supply register write
        if (wrMs) begin
            if (inStop && reqMode == sms_pkg::MODE_SLEEP) begin
                // Whole write dropped, no state change
                st_next.modeSupply = st_reg.modeSupply;
            end else if (reqMode == sms_pkg::MODE_SOFT_RESET) begin
                st_next.softReset = 1'b1;
            end else if (inStop && reqMode == sms_pkg::MODE_NORMAL) begin
                // Leaving stop: only the mode field may move
                st_next.modeSupply[sms_pkg::MS_MODE_LSB +: 2] = sms_pkg::MODE_NORMAL;
                st_next.modeReq = sms_pkg::MODE_NORMAL;
                st_next.modeReqValid = 1'b1;
                if (frame.data[sms_pkg::MS_LOW_FIELDS_MSB:0]
                        != st_reg.modeSupply[sms_pkg::MS_LOW_FIELDS_MSB:0]) begin
                    st_next.spiFail = 1'b1;
                end
            end else begin
                st_next.modeSupply = frame.data & sms_pkg::MODE_SUPPLY_RW_MASK;
                st_next.modeReq = reqMode;
                st_next.modeReqValid = 1'b1;
            end
        end

        // Hardware control 0 write, locked bits hold their value
        if (wrHw) begin
            st_next.hwCtrl0 = frame.data & sms_pkg::HW_CTRL0_RW_MASK;
            if (cfgLock1) begin
                st_next.hwCtrl0[sms_pkg::HW_SRST_BIT] = st_reg.hwCtrl0[sms_pkg::HW_SRST_BIT];
            end
            if (cfgLock0) begin
                st_next.hwCtrl0[sms_pkg::HW_CP_BIT] = st_reg.hwCtrl0[sms_pkg::HW_CP_BIT];
            end
        end

        // Watchdog control storage; its fields act elsewhere
        if (wrWd) begin
            st_next.wdCtrl = frame.data & sms_pkg::WATCHDOG_CONTROL_RW_MASK;
        end

        // Soft reset: non-development-mode power-on values except locked bits
        if (st_next.softReset) begin
            st_next.modeSupply = sms_pkg::MODE_SUPPLY_RESET;
            if (cfgLock1) begin
                hwKeep[sms_pkg::HW_SRST_BIT] = 1'b1;
            end
            if (cfgLock0) begin
                hwKeep[sms_pkg::HW_CP_BIT] = 1'b1;
            end
            st_next.hwCtrl0 = (st_reg.hwCtrl0 & hwKeep) | sms_pkg::HW_CTRL0_RESET;
            st_next.wdCtrl = sms_pkg::WATCHDOG_CONTROL_RESET;
            st_next.resetLow = !st_reg.hwCtrl0[sms_pkg::HW_SRST_BIT];
        end

        // Restart entry wins over a same-cycle write or soft reset
        if (enterRestart) begin
            st_next.modeSupply = st_reg.modeSupply & sms_pkg::MODE_SUPPLY_RESTART_KEEP;
            st_next.modeSupply[sms_pkg::MS_MODE_LSB +: 2] = sms_pkg::MODE_NORMAL;
            st_next.modeSupply[sms_pkg::MS_POLICY_LSB +: 2] = sms_pkg::POL_OFF;
            st_next.hwCtrl0 = st_reg.hwCtrl0 & sms_pkg::HW_CTRL0_RESTART_KEEP;
            st_next.wdCtrl = (st_reg.wdCtrl & sms_pkg::WATCHDOG_CONTROL_RESTART_KEEP)
                | sms_pkg::WATCHDOG_CONTROL_RESTART_SET;
        end

        // Overtemperature shuts the secondary regulator policy off
        if (overTemp) begin
            st_next.modeSupply[sms_pkg::MS_POLICY_LSB +: 2] = sms_pkg::POL_OFF;
        end

        // Overvoltage always flags; reaction only when enabled
        if (primaryOvEvent) begin
            st_next.ovFlag = 1'b1;
            st_next.ovRestart = st_reg.modeSupply[sms_pkg::MS_OV_EN_BIT];
        end

        // Secondary regulator switch from policy and device state
        unique case (policy)
            sms_pkg::POL_OFF: st_next.secOn = 1'b0;
            sms_pkg::POL_NORMAL: st_next.secOn = (sbcState == sms_pkg::SMS_ST_NORMAL);
            sms_pkg::POL_NORMAL_STOP: begin
                st_next.secOn = (sbcState == sms_pkg::SMS_ST_NORMAL) || inStop;
            end
            sms_pkg::POL_ALWAYS: begin
                st_next.secOn = !(sbcState == sms_pkg::SMS_ST_RESTART
                    || sbcState == sms_pkg::SMS_ST_FAILSAFE
                    || (sbcState == sms_pkg::SMS_ST_INIT && !devMode));
            end
        endcase

        // Fail output: software request only on a fail-output pin;
        // a failure keeps it active whatever software does
        st_next.failOut = (st_reg.hwCtrl0[sms_pkg::HW_FO_BIT] && pinIsFailOutput)
            || failureActive;
    end

    // Power-on reset; development mode starts the regulator policy at always on
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.modeSupply <= sms_pkg::MODE_SUPPLY_RESET;
            if (devMode) begin
                st_reg.modeSupply[sms_pkg::MS_POLICY_LSB +: 2] <= sms_pkg::POL_ALWAYS;
            end
            st_reg.hwCtrl0 <= sms_pkg::HW_CTRL0_RESET;
            st_reg.wdCtrl <= sms_pkg::WATCHDOG_CONTROL_RESET;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    assign modeRequest = st_reg.modeReq;
    assign modeRequestValid = st_reg.modeReqValid;
    assign softResetRequest = st_reg.softReset;
    assign resetPinLowRequest = st_reg.resetLow;
    assign spiFailSet = st_reg.spiFail;
    assign primaryOvFlagSet = st_reg.ovFlag;
    assign primaryOvRestartReq = st_reg.ovRestart;
    assign secRegOn = st_reg.secOn;
    assign resetThresholdSel = st_reg.modeSupply[1:0];
    assign chargePumpOn = st_reg.hwCtrl0[sms_pkg::HW_CP_BIT];
    assign failOutputActive = st_reg.failOut;
    assign wdFailCountSel = st_reg.hwCtrl0[sms_pkg::HW_WDCNT_BIT];
    assign watchdogControl = st_reg.wdCtrl;
endmodule

// ---- verif/sms_mode_supply_regs_checker.sv ----
// Port-level assertions for the mode/supply register bank.
// Assumes one mclk domain; bound onto every instance of the block.
`timescale 1ns/1ps
module sms_mode_supply_regs_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic spiCsN,
    input wire logic spiSdoOe,
    input wire logic enterRestart,
    input wire logic primaryOvEvent,
    input wire logic failureActive,
    input wire logic pinIsFailOutput,
    input wire logic [1:0] modeRequest,
    input wire logic modeRequestValid,
    input wire logic softResetRequest,
    input wire logic resetPinLowRequest,
    input wire logic primaryOvFlagSet,
    input wire logic primaryOvRestartReq,
    input wire logic [1:0] resetThresholdSel,
    input wire logic chargePumpOn,
    input wire logic failOutputActive,
    input wire logic wdFailCountSel,
    input wire logic [7:0] watchdogControl
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Restart entry seen by the bank
    sequence s_restart;
        ce && enterRestart;
    endsequence
    // Chip select parked long enough for any frame to have closed
    sequence s_idle;
        spiCsN [*8];
    endsequence

    AST_OV_FLAG: assert property (ce && primaryOvEvent |=> primaryOvFlagSet)
        else $error("overvoltage event gave no flag pulse");
    AST_OV_RESTART: assert property (primaryOvRestartReq |-> primaryOvFlagSet)
        else $error("overvoltage restart request without flag");
    AST_MODE_PULSE: assert property (modeRequestValid |->
        modeRequest != sms_pkg::MODE_SOFT_RESET ##1 !modeRequestValid)
        else $error("mode request malformed or longer than one cycle");
    AST_SOFT_RESET: assert property (softResetRequest |-> !modeRequestValid
        && watchdogControl == sms_pkg::WATCHDOG_CONTROL_RESET && resetThresholdSel == 2'h0)
        else $error("soft reset left registers off their reset values");
    AST_RST_PIN: assert property (resetPinLowRequest |-> softResetRequest)
        else $error("reset pin request outside soft reset");
    AST_RESTART_WD: assert property (s_restart |=> watchdogControl[3:0] == 4'h4)
        else $error("restart value of watchdog control wrong");
    AST_RESTART_KEEP: assert property (s_restart |=> $stable(resetThresholdSel)
        && $stable(chargePumpOn) && $stable(wdFailCountSel))
        else $error("restart disturbed kept bits");
    AST_FAIL_HOLD: assert property (ce && failureActive |=> failOutputActive)
        else $error("failure did not hold fail output");
    AST_FAIL_OFF: assert property (ce && !failureActive && !pinIsFailOutput
        |=> !failOutputActive)
        else $error("fail output active on a pin not configured for it");
    AST_SDO_IDLE: assert property (s_idle |-> !spiSdoOe)
        else $error("data output driven with chip select high");
endmodule

bind sms_mode_supply_regs sms_mode_supply_regs_checker chk (.mclk, .rst, .ce, .spiCsN,
    .spiSdoOe, .enterRestart, .primaryOvEvent, .failureActive, .pinIsFailOutput,
    .modeRequest, .modeRequestValid, .softResetRequest, .resetPinLowRequest,
    .primaryOvFlagSet, .primaryOvRestartReq, .resetThresholdSel, .chargePumpOn,
    .failOutputActive, .wdFailCountSel, .watchdogControl);

// ---- verif/sms_spi_host.sv ----
// Behavioural SPI host that plays the microcontroller side of the bank.
// Assumes the bench mclk; SCLK half period is four mclk cycles.
`timescale 1ns/1ps
module sms_spi_host (
    input wire logic mclk,
    input wire logic sdo,
    output logic csN,
    output logic sclk,
    output logic sdi
);
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // Frame of n bits, MSB first; SCLK stands low outside frames
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        csN <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            sdi <= tx[15 - i];
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            rx = {rx[14:0], sdo};
            repeat (4) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        csN <= 1'b1;
        // Released line flips so a held value cannot pass for data
        sdi <= ~sdi;
        repeat (8) @(posedge mclk);
    endtask
endmodule

// ---- verif/test_sms_mode_supply_regs.sv ----
// Self-checking bench for the mode/supply register bank.
// Assumes the SPI host model drives the pins; state inputs come from here.
`timescale 1ns/1ps
module test_sms_mode_supply_regs;
    typedef struct packed {
        logic [15:0] tx;
        logic [15:0] exp;
    } sms_row_t;

    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, devMode = 1'b0;
    logic spiCsN, spiSclk, spiSdi, spiSdo, spiSdoOe;
    sms_pkg::sms_sbc_state_t sbcState = sms_pkg::SMS_ST_NORMAL;
    logic enterRestart = 1'b0, overTemp = 1'b0, primaryOvEvent = 1'b0;
    logic cfgLock0 = 1'b0, cfgLock1 = 1'b0, failureActive = 1'b0, pinIsFailOutput = 1'b1;
    logic [1:0] modeRequest, resetThresholdSel;
    logic modeRequestValid, softResetRequest, resetPinLowRequest, spiFailSet;
    logic primaryOvFlagSet, primaryOvRestartReq, secRegOn, chargePumpOn;
    logic failOutputActive, wdFailCountSel, failSeen = 1'b0, rstLowSeen = 1'b0;
    logic ovRstSeen = 1'b0;
    logic [1:0] lastMode = 2'h0;
    logic [7:0] watchdogControl;
    logic [15:0] rx;
    int errorCnt = 0, checked = 0, cycles = 0;
    // Reads and writes with the full two-byte reply expected
    sms_row_t rows [10] = '{'{16'h0100, 16'h0000}, '{16'h0200, 16'h0000},
        '{16'h0300, 16'h0014}, '{16'h813f, 16'h0000}, '{16'h0100, 16'h1f1f},
        '{16'h82ff, 16'h1f00}, '{16'h0200, 16'h1f65}, '{16'h83ff, 16'h1f14},
        '{16'h0300, 16'h1ff7}, '{16'h0500, 16'h1f00}};

    sms_spi_host host (.mclk(mclk), .sdo(spiSdo), .csN(spiCsN), .sclk(spiSclk), .sdi(spiSdi));
    sms_mode_supply_regs dut (.mclk(mclk), .rst(rst), .ce(ce), .spiCsN(spiCsN),
        .spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe),
        .sbcState(sbcState), .devMode(devMode), .enterRestart(enterRestart),
        .overTemp(overTemp), .primaryOvEvent(primaryOvEvent), .cfgLock0(cfgLock0),
        .cfgLock1(cfgLock1), .failureActive(failureActive), .pinIsFailOutput(pinIsFailOutput),
        .modeRequest(modeRequest), .modeRequestValid(modeRequestValid),
        .softResetRequest(softResetRequest), .resetPinLowRequest(resetPinLowRequest),
        .spiFailSet(spiFailSet), .primaryOvFlagSet(primaryOvFlagSet),
        .primaryOvRestartReq(primaryOvRestartReq), .secRegOn(secRegOn),
        .resetThresholdSel(resetThresholdSel), .chargePumpOn(chargePumpOn),
        .failOutputActive(failOutputActive), .wdFailCountSel(wdFailCountSel),
        .watchdogControl(watchdogControl));

    always #25 mclk = ~mclk;

    task automatic report_and_stop();
        $display("errors %0d checks %0d", errorCnt, checked);
        if (errorCnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One frame; only the reply data byte is compared
    task automatic acc(input logic [15:0] tx, input logic [7:0] exp);
        logic [15:0] r;
        host.xfer(tx, 16, r);
        check("reply", {8'h00, r[7:0]}, {8'h00, exp});
    endtask

    // Pulses are caught here; a hang is cut off at the ceiling
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (spiFailSet) begin
            failSeen <= 1'b1;
        end
        if (resetPinLowRequest) begin
            rstLowSeen <= 1'b1;
        end
        if (primaryOvRestartReq) begin
            ovRstSeen <= 1'b1;
        end
        // Last accepted mode code, to tell refused writes from taken ones
        if (modeRequestValid) begin
            lastMode <= modeRequest;
        end
        if (cycles == 20000) begin
            errorCnt++;
            report_and_stop();
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        foreach (rows[i]) begin
            host.xfer(rows[i].tx, 16, rx);
            check("row", rx, rows[i].exp);
        end
        check("outputs", {2'h0, secRegOn, resetThresholdSel, chargePumpOn, failOutputActive,
            wdFailCountSel, watchdogControl}, 16'h3ff7);
        // Failure holds fail output after the software bit drops
        failureActive <= 1'b1;
        acc(16'h8245, 8'h65);
        check("foHeld", {15'h0, failOutputActive}, 16'h1);
        failureActive <= 1'b0;
        repeat (2) @(posedge mclk);
        check("foFree", {15'h0, failOutputActive}, 16'h0);
        acc(16'h8265, 8'h45);
        check("foSoft", {15'h0, failOutputActive}, 16'h1);
        pinIsFailOutput <= 1'b0;
        repeat (2) @(posedge mclk);
        check("foNotPin", {15'h0, failOutputActive}, 16'h0);
        pinIsFailOutput <= 1'b1;
        // Restart entry
        enterRestart <= 1'b1;
        @(posedge mclk);
        enterRestart <= 1'b0;
        repeat (2) @(posedge mclk);
        check("restartOut", {14'h0, failOutputActive, secRegOn}, 16'h0);
        acc(16'h0200, 8'h45);
        acc(16'h0100, 8'h03);
        acc(16'h0300, 8'hb4);
        // Overvoltage with its reaction enabled, then overtemperature
        acc(16'h811c, 8'h03);
        primaryOvEvent <= 1'b1;
        @(posedge mclk);
        primaryOvEvent <= 1'b0;
        overTemp <= 1'b1;
        @(posedge mclk);
        overTemp <= 1'b0;
        acc(16'h0100, 8'h04);
        check("ovRestart", {15'h0, ovRstSeen}, 16'h1);
        // Stop requested; in stop, sleep refused and normal taken without low bits
        acc(16'h8184, 8'h04);
        check("modeStop", {14'h0, lastMode}, {14'h0, sms_pkg::MODE_STOP});
        sbcState <= sms_pkg::SMS_ST_STOP;
        acc(16'h8144, 8'h84);
        acc(16'h0100, 8'h84);
        check("modeRefused", {14'h0, lastMode}, {14'h0, sms_pkg::MODE_STOP});
        acc(16'h811f, 8'h84);
        acc(16'h0100, 8'h04);
        check("modeNormal", {14'h0, lastMode}, {14'h0, sms_pkg::MODE_NORMAL});
        check("spiFail", {15'h0, failSeen}, 16'h1);
        sbcState <= sms_pkg::SMS_ST_NORMAL;
        // Short frame is ignored
        host.xfer(16'h81c0, 12, rx);
        acc(16'h0100, 8'h04);
        // Soft reset under both locks, then again with both locks released
        cfgLock0 <= 1'b1;
        cfgLock1 <= 1'b1;
        acc(16'h81c0, 8'h04);
        acc(16'h0200, 8'h44);
        acc(16'h0100, 8'h00);
        acc(16'h0300, 8'h14);
        acc(16'h8200, 8'h44);
        acc(16'h0200, 8'h44);
        check("noRstLow", {15'h0, rstLowSeen}, 16'h0);
        cfgLock0 <= 1'b0;
        cfgLock1 <= 1'b0;
        acc(16'h8200, 8'h44);
        acc(16'h81c0, 8'h00);
        acc(16'h0200, 8'h00);
        check("rstLow", {15'h0, rstLowSeen}, 16'h1);
        // Second reset in development mode, device held in init
        rst <= 1'b1;
        devMode <= 1'b1;
        sbcState <= sms_pkg::SMS_ST_INIT;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        check("devInitOn", {15'h0, secRegOn}, 16'h1);
        acc(16'h0100, 8'h18);
        devMode <= 1'b0;
        repeat (2) @(posedge mclk);
        check("initOff", {15'h0, secRegOn}, 16'h0);
        acc(16'h81c0, 8'h18);
        acc(16'h0100, 8'h00);
        report_and_stop();
    end
endmodule
